// ---- inc/pmw_pkg.sv ----
// types and constants for the power mode and wake control block
// Overview of operation
// - deep power-down keeps only the clock domain and reset pin powered
// - deep power-down exits only on reset pin or clock alarm
// - second alarm flag raises a wake-capable alarm interrupt request
// - after deep power-down all state returns to reset defaults
// - all functional pins are high impedance in deep power-down
// - DMA active in sleep, partial in deep-sleep, off in power-down
// - serial units unclocked in deep-sleep; SPI/I2C slaves still wake
// - USART unclocked in deep-sleep; sync slave or 32 kHz still wakes
// - in sleep any controller-enabled interrupt wakes the processor
// - hardware wake request wakes from sleep and deep-sleep
// - pin interrupt wakes deep-sleep if controller and start enables set
// - brownout irq wakes deep-sleep with all enables and detector running
// - brownout reset from deep-sleep when its reset enable is set
// - watchdog irq wakes deep-sleep with oscillator, enables and feed
// - watchdog reset from deep-sleep with oscillator, enables and feed
// - second alarm wake needs oscillator, bus clock, count, start enable
// - kHz timer wake needs both oscillators, wake value, start enable
// - micro-tick wake needs oscillator, bus clock, start, start enable
// - each USB unit need-clock interrupt wakes from deep-sleep
package pmw_pkg;
    // one-hot mode states
    typedef enum logic [4:0] {
        ST_ACTIVE = 5'h01,
        ST_SLEEP = 5'h02,
        ST_DSLEEP = 5'h04,
        ST_DPD = 5'h08,
        ST_RESTART = 5'h10
    } pmw_state_t;
    typedef enum logic [1:0] {
        REQ_SLEEP = 2'h0,
        REQ_DSLEEP = 2'h1,
        REQ_DPD = 2'h2
    } pmw_req_t;
    typedef enum logic [1:0] {
        DMA_ACTIVE = 2'h0,
        DMA_PARTIAL = 2'h1,
        DMA_OFF = 2'h2
    } pmw_dma_t;
    localparam int NUM_PIN_IRQ = 8;
    // start-enable and interrupt-enable bit positions
    localparam int SE_PIN_LSB = 0;
    localparam int SE_BOD = 8;
    localparam int SE_WDT = 9;
    localparam int SE_RTC_ALARM = 10;
    localparam int SE_RTC_WAKE = 11;
    localparam int SE_MICRO_TICK_TIMER = 12;
    // restart hold time
    localparam int RST_HOLD_NS = 1000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 8;
    typedef struct packed {
        logic [31:0] irq_enable;
        logic [31:0] wake_start_enable_0;
        logic [31:0] wake_start_enable_1;
        logic bod_irq_en;
        logic bod_reset_en;
        logic bod_keep_running;
        logic wdosc_powered;
        logic wdosc_keep_running;
        logic wdt_enable;
        logic wdt_reset_en;
        logic wdt_irq_en;
        logic wdt_fed;
        logic rtc_osc_1hz_en;
        logic rtc_osc_1khz_en;
        logic rtc_bus_clk_en;
        logic rtc_count_loaded;
        logic rtc_wake_loaded;
        logic micro_tick_timer_bus_clk_en;
        logic micro_tick_timer_started;
        logic spi_slave_mode;
        logic i2c_slave_mode;
        logic usart_sync_slave;
        logic usart_32k_mode;
    } pmw_cfg_t;
    typedef struct packed {
        logic [31:0] irq_pending;
        logic [NUM_PIN_IRQ-1:0] pin_irq;
        logic bod_irq;
        logic bod_reset;
        logic wdt_irq;
        logic wdt_reset;
        logic rtc_wake_irq;
        logic micro_tick_timer_irq;
        logic spi_irq;
        logic i2c_irq;
        logic usart_irq;
        logic full_speed_usb_need_clk;
        logic high_speed_usb_need_clk;
        logic enet_irq;
        logic dma_irq;
        logic hardware_wake_request;
    } pmw_evt_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic main_clk_en;
        logic serial_clk_en;
        logic periph_clk_en;
        logic flash_standby;
        logic core_pwr_en;
        logic rtc_pwr_en;
        logic pad_hiz;
        logic sys_reset;
        pmw_dma_t dma_mode;
    } pmw_ctl_t;
    typedef struct packed {
        pmw_state_t st;
        pmw_ctl_t ctl;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic alarm_irq;
        logic wake_pulse;
    } pmw_reg_t;
endpackage

// ---- rtl/pmw_wake_qual.sv ----
// wake source qualification for sleep, deep-sleep and power-down
`timescale 1ns/10ps
`default_nettype none
module pmw_wake_qual (
    input wire pmw_pkg::pmw_cfg_t cfg,
    input wire pmw_pkg::pmw_evt_t evt,
    input wire logic alarm_irq,
    output logic sleep_wake,
    output logic ds_wake,
    output logic ds_reset,
    output logic dpd_wake
);
    logic [31:0] se0;
    logic [31:0] ie;
    logic [pmw_pkg::NUM_PIN_IRQ-1:0] pin_ok;
    logic bod_ok, wdt_ok, alarm_ok, rtcw_ok, micro_tick_timer_ok, serial_ok;
    assign se0 = cfg.wake_start_enable_0;
    assign ie = cfg.irq_enable;
    assign sleep_wake = |(evt.irq_pending & ie)
        | evt.hardware_wake_request;
    assign pin_ok = evt.pin_irq
        & ie[pmw_pkg::SE_PIN_LSB +: pmw_pkg::NUM_PIN_IRQ]
        & (se0[pmw_pkg::SE_PIN_LSB +: pmw_pkg::NUM_PIN_IRQ]
        | cfg.wake_start_enable_1[pmw_pkg::SE_PIN_LSB
        +: pmw_pkg::NUM_PIN_IRQ]);
    assign bod_ok = evt.bod_irq & ie[pmw_pkg::SE_BOD]
        & se0[pmw_pkg::SE_BOD] & cfg.bod_irq_en
        & cfg.bod_keep_running;
    assign wdt_ok = evt.wdt_irq & cfg.wdosc_powered
        & cfg.wdosc_keep_running & ie[pmw_pkg::SE_WDT]
        & se0[pmw_pkg::SE_WDT] & cfg.wdt_enable & cfg.wdt_fed
        & cfg.wdt_irq_en;
    assign alarm_ok = alarm_irq & cfg.rtc_osc_1hz_en
        & cfg.rtc_bus_clk_en & cfg.rtc_count_loaded
        & se0[pmw_pkg::SE_RTC_ALARM];
    assign rtcw_ok = evt.rtc_wake_irq & cfg.rtc_osc_1hz_en
        & cfg.rtc_osc_1khz_en & cfg.rtc_wake_loaded
        & se0[pmw_pkg::SE_RTC_WAKE];
    assign micro_tick_timer_ok = evt.micro_tick_timer_irq & cfg.wdosc_powered
        & cfg.micro_tick_timer_bus_clk_en & cfg.micro_tick_timer_started
        & se0[pmw_pkg::SE_MICRO_TICK_TIMER];
    assign serial_ok = (evt.spi_irq & cfg.spi_slave_mode)
        | (evt.i2c_irq & cfg.i2c_slave_mode)
        | (evt.usart_irq & (cfg.usart_sync_slave
        | cfg.usart_32k_mode));
    assign ds_wake = |pin_ok | bod_ok | wdt_ok | alarm_ok | rtcw_ok
        | micro_tick_timer_ok | serial_ok | evt.hardware_wake_request
        | evt.full_speed_usb_need_clk
        | evt.high_speed_usb_need_clk
        | evt.enet_irq | evt.dma_irq;
    assign ds_reset = (evt.bod_reset & cfg.bod_reset_en)
        | (evt.wdt_reset & cfg.wdosc_powered & cfg.wdt_enable
        & cfg.wdt_reset_en & cfg.wdt_fed);
    // only the alarm; the reset pin is handled by the caller
    assign dpd_wake = alarm_irq;
endmodule
`default_nettype wire

// ---- rtl/pmw_power_ctrl.sv ----
// reduced power mode sequencer with wake qualification
`timescale 1ns/10ps
`default_nettype none
module pmw_power_ctrl #(
    parameter int RST_HOLD = pmw_pkg::RST_HOLD_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic enter_req,
    input wire pmw_pkg::pmw_req_t enter_mode,
    input wire logic rtc_second_alarm_flag,
    input wire pmw_pkg::pmw_cfg_t cfg,
    input wire pmw_pkg::pmw_evt_t evt,
    output pmw_pkg::pmw_state_t mode,
    output pmw_pkg::pmw_ctl_t ctl,
    output logic rtc_alarm_wake_irq,
    output logic wake_pulse
);
    localparam int RST_CNT_W = pmw_pkg::RST_CNT_W;

    pmw_pkg::pmw_reg_t r_q;
    pmw_pkg::pmw_reg_t r_d;
    logic sleep_wake;
    logic ds_wake;
    logic ds_reset;
    logic dpd_wake;
    logic pin_req;

    pmw_wake_qual u_qual (
        .cfg(cfg),
        .evt(evt),
        .alarm_irq(r_q.alarm_irq),
        .sleep_wake(sleep_wake),
        .ds_wake(ds_wake),
        .ds_reset(ds_reset),
        .dpd_wake(dpd_wake)
    );

    assign pin_req = ~reset_pin_n;

    // per-mode power, clock and pad controls
    function automatic pmw_pkg::pmw_ctl_t ctl_of(
        input pmw_pkg::pmw_state_t s
    );
        pmw_pkg::pmw_ctl_t c;
        c.cpu_clk_en = 1'b1;
        c.main_clk_en = 1'b1;
        c.serial_clk_en = 1'b1;
        c.periph_clk_en = 1'b1;
        c.flash_standby = 1'b0;
        c.core_pwr_en = 1'b1;
        c.rtc_pwr_en = 1'b1;
        c.pad_hiz = 1'b0;
        c.sys_reset = 1'b0;
        c.dma_mode = pmw_pkg::DMA_ACTIVE;
        unique case (s)
            pmw_pkg::ST_ACTIVE: begin
            end
            pmw_pkg::ST_SLEEP: begin
                c.cpu_clk_en = 1'b0;
                c.dma_mode = pmw_pkg::DMA_ACTIVE;
            end
            pmw_pkg::ST_DSLEEP: begin
                c.cpu_clk_en = 1'b0;
                c.main_clk_en = 1'b0;
                c.serial_clk_en = 1'b0;
                c.periph_clk_en = 1'b0;
                c.flash_standby = 1'b1;
                c.dma_mode = pmw_pkg::DMA_PARTIAL;
            end
            pmw_pkg::ST_DPD: begin
                c.cpu_clk_en = 1'b0;
                c.main_clk_en = 1'b0;
                c.serial_clk_en = 1'b0;
                c.periph_clk_en = 1'b0;
                c.core_pwr_en = 1'b0;
                c.pad_hiz = 1'b1;
                c.dma_mode = pmw_pkg::DMA_OFF;
            end
            pmw_pkg::ST_RESTART: begin
                c.cpu_clk_en = 1'b0;
                c.sys_reset = 1'b1;
            end
            default: begin
                c.sys_reset = 1'b1;
            end
        endcase
        return c;
    endfunction

    always_comb begin
        r_d = r_q;
        r_d.wake_pulse = 1'b0;
        // flag level from the clock domain drives the wake request
        r_d.alarm_irq = rtc_second_alarm_flag;
        unique case (r_q.st)
            pmw_pkg::ST_ACTIVE: begin
                if (pin_req) begin
                    r_d.st = pmw_pkg::ST_RESTART;
                end else if (enter_req) begin
                    unique case (enter_mode)
                        pmw_pkg::REQ_SLEEP: begin
                            r_d.st = pmw_pkg::ST_SLEEP;
                        end
                        pmw_pkg::REQ_DSLEEP: begin
                            r_d.st = pmw_pkg::ST_DSLEEP;
                        end
                        pmw_pkg::REQ_DPD: begin
                            r_d.st = pmw_pkg::ST_DPD;
                        end
                        default: begin
                            r_d.st = pmw_pkg::ST_ACTIVE;
                        end
                    endcase
                end
            end
            pmw_pkg::ST_SLEEP: begin
                if (pin_req) begin
                    r_d.st = pmw_pkg::ST_RESTART;
                end else if (sleep_wake) begin
                    r_d.st = pmw_pkg::ST_ACTIVE;
                    r_d.wake_pulse = 1'b1;
                end
            end
            pmw_pkg::ST_DSLEEP: begin
                if (pin_req || ds_reset) begin
                    r_d.st = pmw_pkg::ST_RESTART;
                end else if (ds_wake) begin
                    r_d.st = pmw_pkg::ST_ACTIVE;
                    r_d.wake_pulse = 1'b1;
                end
            end
            pmw_pkg::ST_DPD: begin
                // nothing survives, so any exit is a full restart
                if (pin_req || dpd_wake) begin
                    r_d.st = pmw_pkg::ST_RESTART;
                end
            end
            pmw_pkg::ST_RESTART: begin
                if (pin_req) begin
                    r_d.rst_cnt = RST_CNT_W'(RST_HOLD - 1);
                end else if (r_q.rst_cnt == '0) begin
                    r_d.st = pmw_pkg::ST_ACTIVE;
                    r_d.wake_pulse = 1'b1;
                end else begin
                    r_d.rst_cnt = r_q.rst_cnt - 1'b1;
                end
            end
            default: begin
                r_d.st = pmw_pkg::ST_RESTART;
            end
        endcase
        if (r_d.st == pmw_pkg::ST_RESTART &&
            r_q.st != pmw_pkg::ST_RESTART) begin
            r_d.rst_cnt = RST_CNT_W'(RST_HOLD - 1);
        end
        r_d.ctl = ctl_of(r_d.st);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r_q.st <= pmw_pkg::ST_ACTIVE;
            r_q.ctl.cpu_clk_en <= 1'b1;
            r_q.ctl.main_clk_en <= 1'b1;
            r_q.ctl.serial_clk_en <= 1'b1;
            r_q.ctl.periph_clk_en <= 1'b1;
            r_q.ctl.flash_standby <= 1'b0;
            r_q.ctl.core_pwr_en <= 1'b1;
            r_q.ctl.rtc_pwr_en <= 1'b1;
            r_q.ctl.pad_hiz <= 1'b0;
            r_q.ctl.sys_reset <= 1'b0;
            r_q.ctl.dma_mode <= pmw_pkg::DMA_ACTIVE;
            r_q.rst_cnt <= '0;
            r_q.alarm_irq <= 1'b0;
            r_q.wake_pulse <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign mode = r_q.st;
    assign ctl = r_q.ctl;
    assign rtc_alarm_wake_irq = r_q.alarm_irq;
    assign wake_pulse = r_q.wake_pulse;

    a_dpd_power_off:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DPD |->
        !r_q.ctl.core_pwr_en && r_q.ctl.rtc_pwr_en)
    else $error("power-down left core powered or clock domain off");

    a_dpd_pads_hiz:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DPD |-> r_q.ctl.pad_hiz)
    else $error("pads driven in power-down");

    a_dpd_exit_only:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DPD && reset_pin_n && !r_q.alarm_irq
        |=> r_q.st == pmw_pkg::ST_DPD)
    else $error("power-down left without reset pin or alarm");

    a_alarm_irq_follow:
    assert property (@(posedge clock) disable iff (reset)
        rtc_second_alarm_flag |=> rtc_alarm_wake_irq)
    else $error("alarm flag did not raise wake request");

    a_restart_hold:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DPD && r_q.alarm_irq
        |=> r_q.ctl.sys_reset && r_q.rst_cnt == RST_CNT_W'(RST_HOLD - 1))
    else $error("restart did not load full hold count");

    a_restart_done:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_RESTART && r_q.rst_cnt == '0 && reset_pin_n
        |=> r_q.st == pmw_pkg::ST_ACTIVE && wake_pulse
        && !r_q.ctl.sys_reset)
    else $error("restart did not end in active");

    a_dma_by_mode:
    assert property (@(posedge clock) disable iff (reset)
        (r_q.st == pmw_pkg::ST_DSLEEP) ==
        (r_q.ctl.dma_mode == pmw_pkg::DMA_PARTIAL))
    else $error("dma mode wrong for deep-sleep");

    a_ds_serial_off:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DSLEEP |-> !r_q.ctl.serial_clk_en)
    else $error("serial clock running in deep-sleep");

    a_sleep_wakeup:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_SLEEP && reset_pin_n
        && |(evt.irq_pending & cfg.irq_enable)
        |=> r_q.st == pmw_pkg::ST_ACTIVE ##1 !wake_pulse)
    else $error("enabled interrupt did not wake from sleep");

    a_hw_wake_ds:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DSLEEP && reset_pin_n && !ds_reset
        && evt.hardware_wake_request |=> r_q.st == pmw_pkg::ST_ACTIVE)
    else $error("hardware wake ignored in deep-sleep");

    a_ds_reset_go:
    assert property (@(posedge clock) disable iff (reset)
        r_q.st == pmw_pkg::ST_DSLEEP && evt.bod_reset && cfg.bod_reset_en
        |=> r_q.st == pmw_pkg::ST_RESTART)
    else $error("brownout reset ignored in deep-sleep");

    a_pin_any_mode:
    assert property (@(posedge clock) disable iff (reset)
        !reset_pin_n && r_q.st != pmw_pkg::ST_RESTART
        |=> r_q.st == pmw_pkg::ST_RESTART)
    else $error("reset pin did not restart");
endmodule
`default_nettype wire

// ---- sim/pmw_wake_src_model.sv ----
// peripheral side model that raises one wake event level per code
`timescale 1ns/10ps
`default_nettype none
module pmw_wake_src_model (
    input wire logic [4:0] src_sel,
    output var pmw_pkg::pmw_evt_t evt,
    output logic alarm_flag
);
    // level held for as long as the code stands
    always_comb begin
        evt = '0;
        alarm_flag = 1'b0;
        case (src_sel)
            5'h01: evt.irq_pending[3] = 1'b1;
            5'h02: evt.pin_irq[2] = 1'b1;
            5'h03: evt.bod_irq = 1'b1;
            5'h04: evt.bod_reset = 1'b1;
            5'h05: evt.wdt_irq = 1'b1;
            5'h06: evt.wdt_reset = 1'b1;
            5'h07: evt.rtc_wake_irq = 1'b1;
            5'h08: evt.micro_tick_timer_irq = 1'b1;
            5'h09: evt.spi_irq = 1'b1;
            5'h0a: evt.i2c_irq = 1'b1;
            5'h0b: evt.usart_irq = 1'b1;
            5'h0c: evt.full_speed_usb_need_clk = 1'b1;
            5'h0d: evt.high_speed_usb_need_clk = 1'b1;
            5'h0e: evt.enet_irq = 1'b1;
            5'h0f: evt.dma_irq = 1'b1;
            5'h10: evt.hardware_wake_request = 1'b1;
            5'h11: alarm_flag = 1'b1;
            default: ;
        endcase
    end
endmodule
`default_nettype wire

// ---- sim/tb_pmw_power_ctrl.sv ----
// self-checking bench for the power mode and wake control block
`timescale 1ns/10ps
`default_nettype none
module tb_pmw_power_ctrl;
    localparam int HOLD = 3;
    localparam logic [10:0] CTL_RST = 11'h7b0;
    localparam pmw_pkg::pmw_req_t SL = pmw_pkg::REQ_SLEEP;
    localparam pmw_pkg::pmw_req_t DS = pmw_pkg::REQ_DSLEEP;
    localparam pmw_pkg::pmw_req_t PD = pmw_pkg::REQ_DPD;
    localparam pmw_pkg::pmw_state_t A = pmw_pkg::ST_ACTIVE;
    localparam pmw_pkg::pmw_state_t S = pmw_pkg::ST_SLEEP;
    localparam pmw_pkg::pmw_state_t D = pmw_pkg::ST_DSLEEP;
    localparam pmw_pkg::pmw_state_t P = pmw_pkg::ST_DPD;
    localparam pmw_pkg::pmw_state_t R = pmw_pkg::ST_RESTART;
    typedef struct packed {
        pmw_pkg::pmw_req_t md;
        logic [4:0] src;
        logic [4:0] kn;
        pmw_pkg::pmw_state_t ex;
    } pmw_row_t;
    // mode, event code, enable knocked out, mode expected
    pmw_row_t rows [46] = '{
        '{SL,5'h01,5'h00,A}, '{SL,5'h01,5'h01,S}, '{SL,5'h10,5'h01,A},
        '{DS,5'h10,5'h00,A}, '{DS,5'h02,5'h00,A}, '{DS,5'h02,5'h02,A},
        '{DS,5'h02,5'h03,D}, '{DS,5'h02,5'h01,D}, '{DS,5'h03,5'h00,A},
        '{DS,5'h03,5'h04,D}, '{DS,5'h03,5'h05,D}, '{DS,5'h04,5'h00,R},
        '{DS,5'h04,5'h06,D}, '{DS,5'h05,5'h00,A}, '{DS,5'h05,5'h08,D},
        '{DS,5'h05,5'h0b,D}, '{DS,5'h05,5'h17,D}, '{DS,5'h05,5'h0a,D},
        '{DS,5'h06,5'h00,R}, '{DS,5'h06,5'h09,D}, '{DS,5'h06,5'h07,D},
        '{DS,5'h11,5'h00,A}, '{DS,5'h11,5'h0e,D}, '{DS,5'h11,5'h0d,D},
        '{DS,5'h07,5'h00,A}, '{DS,5'h07,5'h0f,D}, '{DS,5'h07,5'h10,D},
        '{DS,5'h08,5'h00,A}, '{DS,5'h08,5'h12,D}, '{DS,5'h08,5'h11,D},
        '{DS,5'h09,5'h00,A}, '{DS,5'h09,5'h13,D}, '{DS,5'h0a,5'h00,A},
        '{DS,5'h0a,5'h14,D}, '{DS,5'h0b,5'h00,A}, '{DS,5'h0b,5'h16,A},
        '{DS,5'h0b,5'h15,D}, '{DS,5'h0c,5'h00,A}, '{DS,5'h0d,5'h00,A},
        '{DS,5'h0e,5'h00,A}, '{DS,5'h0f,5'h00,A}, '{PD,5'h11,5'h0c,R},
        '{PD,5'h0e,5'h00,P}, '{PD,5'h01,5'h00,P}, '{PD,5'h04,5'h00,P},
        '{PD,5'h10,5'h00,P}
    };
    logic clock;
    logic reset;
    logic reset_pin_n;
    logic enter_req;
    pmw_pkg::pmw_req_t enter_mode;
    logic [4:0] src_sel;
    logic alarm_flag;
    pmw_pkg::pmw_cfg_t cfg;
    pmw_pkg::pmw_evt_t evt;
    pmw_pkg::pmw_state_t mode;
    pmw_pkg::pmw_ctl_t ctl;
    logic rtc_irq;
    logic wake_pulse;
    int error_cnt;
    int samples_checked;
    int n;

    pmw_power_ctrl #(.RST_HOLD(HOLD)) dut (
        .clock(clock),
        .reset(reset),
        .reset_pin_n(reset_pin_n),
        .enter_req(enter_req),
        .enter_mode(enter_mode),
        .rtc_second_alarm_flag(alarm_flag),
        .cfg(cfg),
        .evt(evt),
        .mode(mode),
        .ctl(ctl),
        .rtc_alarm_wake_irq(rtc_irq),
        .wake_pulse(wake_pulse)
    );
    pmw_wake_src_model far_side (
        .src_sel(src_sel),
        .evt(evt),
        .alarm_flag(alarm_flag)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic pmw_pkg::pmw_cfg_t build_cfg(input logic [4:0] kn);
        pmw_pkg::pmw_cfg_t c;
        c = '1;
        case (kn)
            5'h01: c.irq_enable = '0;
            5'h02: c.wake_start_enable_0 = '0;
            5'h03: begin
                c.wake_start_enable_0 = '0;
                c.wake_start_enable_1 = '0;
            end
            5'h04: c.bod_irq_en = 1'b0;
            5'h05: c.bod_keep_running = 1'b0;
            5'h06: c.bod_reset_en = 1'b0;
            5'h07: c.wdosc_powered = 1'b0;
            5'h08: c.wdt_enable = 1'b0;
            5'h09: c.wdt_reset_en = 1'b0;
            5'h0a: c.wdt_irq_en = 1'b0;
            5'h0b: c.wdt_fed = 1'b0;
            5'h0c: c.rtc_osc_1hz_en = 1'b0;
            5'h0d: c.rtc_bus_clk_en = 1'b0;
            5'h0e: c.rtc_count_loaded = 1'b0;
            5'h0f: c.rtc_osc_1khz_en = 1'b0;
            5'h10: c.rtc_wake_loaded = 1'b0;
            5'h11: c.micro_tick_timer_bus_clk_en = 1'b0;
            5'h12: c.micro_tick_timer_started = 1'b0;
            5'h13: c.spi_slave_mode = 1'b0;
            5'h14: c.i2c_slave_mode = 1'b0;
            5'h15: begin
                c.usart_sync_slave = 1'b0;
                c.usart_32k_mode = 1'b0;
            end
            5'h16: c.usart_sync_slave = 1'b0;
            5'h17: c.wdosc_keep_running = 1'b0;
            5'h1f: c = '0;
            default: ;
        endcase
        return c;
    endfunction

    task automatic chk(input string nm, input logic [15:0] got,
            input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic rst_dut(input logic [4:0] kn);
        @(posedge clock);
        reset <= 1'b1;
        src_sel <= 5'h00;
        reset_pin_n <= 1'b1;
        cfg <= build_cfg(kn);
        repeat (2) @(posedge clock);
        reset <= 1'b0;
    endtask

    task automatic enter(input pmw_pkg::pmw_req_t md);
        @(posedge clock);
        enter_req <= 1'b1;
        enter_mode <= md;
        @(posedge clock);
        enter_req <= 1'b0;
        @(negedge clock);
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        final_report();
    end

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        reset = 1'b1;
        reset_pin_n = 1'b1;
        enter_req = 1'b0;
        enter_mode = SL;
        src_sel = 5'h00;
        cfg = build_cfg(5'h00);
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        chk("mode", mode, A);
        chk("ctl", ctl, CTL_RST);
        chk("alarm irq", rtc_irq, 1'b0);
        chk("wake pulse", wake_pulse, 1'b0);
        foreach (rows[i]) begin
            rst_dut(rows[i].kn);
            enter(rows[i].md);
            @(posedge clock);
            src_sel <= rows[i].src;
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk("mode", mode, rows[i].ex);
        end
        // sleep, an unused mode code, and the reset pin
        rst_dut(5'h00);
        enter(pmw_pkg::pmw_req_t'(2'h3));
        chk("mode", mode, A);
        enter(SL);
        chk("cpu clk", ctl.cpu_clk_en, 1'b0);
        chk("dma", ctl.dma_mode, pmw_pkg::DMA_ACTIVE);
        enter(PD);
        chk("mode", mode, S);
        @(posedge clock);
        reset_pin_n <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        chk("mode", mode, R);
        // deep-sleep with every enable off
        rst_dut(5'h1f);
        enter(DS);
        chk("serial clk", ctl.serial_clk_en, 1'b0);
        chk("dma", ctl.dma_mode, pmw_pkg::DMA_PARTIAL);
        @(posedge clock);
        reset_pin_n <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        chk("mode", mode, R);
        // power-down left by the alarm through a full restart
        rst_dut(5'h1f);
        enter(PD);
        chk("pad hiz", ctl.pad_hiz, 1'b1);
        chk("core pwr", ctl.core_pwr_en, 1'b0);
        chk("rtc pwr", ctl.rtc_pwr_en, 1'b1);
        chk("dma", ctl.dma_mode, pmw_pkg::DMA_OFF);
        @(posedge clock);
        src_sel <= 5'h11;
        @(posedge clock);
        @(negedge clock);
        chk("alarm irq", rtc_irq, 1'b1);
        chk("mode", mode, P);
        @(negedge clock);
        chk("sys reset", ctl.sys_reset, 1'b1);
        n = 0;
        while (mode === R && n < 20) begin
            n++;
            @(negedge clock);
        end
        chk("restart len", n[15:0], 16'(HOLD));
        chk("mode", mode, A);
        chk("wake pulse", wake_pulse, 1'b1);
        chk("ctl", ctl, CTL_RST);
        @(negedge clock);
        chk("wake pulse", wake_pulse, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
